// [verilog/ctm_pkg.sv]
// Shared constants and carriers for the CPU tag, mirroring and counter block.
// Assumes a three-port switch; port 0..2, one clock domain.
package ctm_pkg;
    localparam int        NPORT     = 3;
    localparam int        ADDR_W    = 8;
    localparam int        CNT_W     = 32;
    localparam logic [1:0] KIND_CPU = 2'h3;
    localparam logic [1:0] KIND_NET = 2'h0;
    localparam logic [1:0] DEST_ALL = 2'h3;

    // Register offsets (byte addresses, word aligned)
    localparam logic [7:0] OFF_MIRROR  = 8'h00;
    localparam logic [7:0] OFF_INKIND  = 8'h04;
    localparam logic [7:0] OFF_EGKIND  = 8'h08;
    localparam logic [7:0] OFF_INGSET  = 8'h0C;
    localparam logic [7:0] OFF_LRN0    = 8'h10;
    localparam logic [7:0] OFF_FLT0    = 8'h20;
    localparam logic [7:0] OFF_STEP    = 8'h04;

    // Mirror setup field positions
    localparam int MIR_RXEN  = 0;
    localparam int MIR_TXEN  = 1;
    localparam int MIR_FILT  = 2;
    localparam int MIR_PORTS = 4;
    localparam int MIR_SNIFF = 8;
    localparam int MIR_SNEN  = 10;

    // Special tag VID bit positions
    localparam int VID_LOOKUP = 3;
    localparam int VID_STPOVR = 4;
    localparam int VID_CALCPR = 5;
    localparam int VID_VLANRU = 6;
    localparam int VID_APRI   = 7;

    typedef struct packed {
        logic        valid;
        logic [1:0]  srcPort;
        logic        filtered;
        logic [2:0]  fwdMask;
    } ctm_fwd_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  srcPort;
        logic [15:0] tag;
        logic [2:0]  pri;
        logic        igmpMon;
        logic        daFound;
        logic        daStatic;
        logic        daAge;
        logic        daPriEn;
        logic [2:0]  daPri;
        logic [2:0]  lookupMask;
        logic        lookupOvr;
        logic [2:0]  contentPri;
        logic        hasInner;
    } ctm_cpu_in_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  destMask;
        logic        stpOverride;
        logic [2:0]  pri;
        logic        vlanRules;
        logic        skipTag;
        logic        learnReq;
    } ctm_cpu_dec_t;
endpackage : ctm_pkg

// [verilog/ctm_tag_mirror.sv]
// Forwarding extras: port mirroring, CPU special tag decode/encode, per-port counters.
// Assumes the switch engine supplies one-cycle descriptor pulses; registers via plain port.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ctm_tag_mirror (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           regAddr,
    input  wire logic [31:0]          regWrData,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic [31:0]               regRdData,
    input  wire ctm_pkg::ctm_fwd_t    fwdIn,
    output ctm_pkg::ctm_fwd_t         fwdOut,
    input  wire ctm_pkg::ctm_cpu_in_t cpuIn,
    output ctm_pkg::ctm_cpu_dec_t     cpuDec,
    input  wire logic [1:0]           egPort,
    input  wire logic                 egValid,
    input  wire ctm_pkg::ctm_cpu_in_t egInfo,
    output logic                      egInsert,
    output logic [15:0]               egTag,
    output logic                      egInnerFollows,
    input  wire logic [2:0]           cpuPortState,
    input  wire logic [2:0]           learnDiscard,
    input  wire logic [2:0]           ingressFiltered,
    input  wire logic [2:0]           rateDrop
);
    logic [31:0] mirrorCfg;
    logic [5:0]  inKind;
    logic [5:0]  egKind;
    logic [2:0]  ingSetup;
    logic [ctm_pkg::CNT_W-1:0] lrnCnt [ctm_pkg::NPORT];
    logic [ctm_pkg::CNT_W-1:0] fltCnt [ctm_pkg::NPORT];
    logic [2:0]  mirPorts;
    logic [1:0]  sniffPort;
    logic [2:0]  sniffMask;
    logic        sniffEn;
    logic [2:0]  next_mask;
    logic [2:0]  srcOneHot;
    logic [15:0] next_tag;
    logic [2:0]  cpuDest;
    logic [2:0]  egOneHot;
    logic [2:0]  inCpuMask;
    logic [2:0]  egCpuMask;
    logic [2:0]  cpuSrcOneHot;
    logic        egToCpu;

    // single sniffer field, mirrored set is a bitmask
    assign mirPorts  = mirrorCfg[ctm_pkg::MIR_PORTS +: 3];
    assign sniffPort = mirrorCfg[ctm_pkg::MIR_SNIFF +: 2];
    assign sniffEn   = mirrorCfg[ctm_pkg::MIR_SNEN] && (sniffPort != ctm_pkg::DEST_ALL);
    assign sniffMask = sniffEn ? (3'h1 << sniffPort) : 3'h0;
    assign srcOneHot = 3'h1 << fwdIn.srcPort;

    always_comb begin
        next_mask = fwdIn.fwdMask;
        // rx mirror, filtered only when enabled
        if (mirrorCfg[ctm_pkg::MIR_RXEN] && mirPorts[fwdIn.srcPort]
            && (!fwdIn.filtered || mirrorCfg[ctm_pkg::MIR_FILT])) begin
            next_mask = next_mask | sniffMask;
        end
        if (mirrorCfg[ctm_pkg::MIR_TXEN] && |(fwdIn.fwdMask & mirPorts)) begin
            next_mask = next_mask | sniffMask;
        end
        // never back out the receiving port
        next_mask = next_mask & ~srcOneHot;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fwdOut <= '0;
        end else begin
            fwdOut.valid    <= fwdIn.valid;
            fwdOut.srcPort  <= fwdIn.srcPort;
            fwdOut.filtered <= fwdIn.filtered;
            fwdOut.fwdMask  <= fwdIn.valid ? next_mask : 3'h0;
        end
    end

    // per-port kind decode; only a port code of 3 marks a CPU port
    genvar k;
    generate
        for (k = 0; k < ctm_pkg::NPORT; k++) begin : g_kind
            assign inCpuMask[k] = (inKind[2*k +: 2] == ctm_pkg::KIND_CPU);
            assign egCpuMask[k] = (egKind[2*k +: 2] == ctm_pkg::KIND_CPU);
        end
    endgenerate

    assign cpuSrcOneHot = 3'h1 << cpuIn.srcPort;

    assign cpuDest = (cpuIn.tag[1:0] == ctm_pkg::DEST_ALL) ? 3'h7 : (3'h1 << cpuIn.tag[1:0]);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpuDec <= '0;
        end else begin
            // decode only on a port set to CPU kind
            cpuDec.valid <= cpuIn.valid && |(inCpuMask & cpuSrcOneHot);
            // special tag always removed on egress
            cpuDec.skipTag <= 1'b1;
            if (cpuIn.tag[ctm_pkg::VID_LOOKUP]) begin
                // lookup result, learning gated by setup and state
                cpuDec.destMask    <= cpuIn.lookupMask & ~cpuSrcOneHot;
                cpuDec.stpOverride <= cpuIn.lookupOvr;
                cpuDec.learnReq    <= ingSetup[cpuIn.srcPort] && |cpuPortState[1:0];
            end else begin
                // direct select with tag override, source excluded
                cpuDec.destMask    <= cpuDest & ~cpuSrcOneHot;
                cpuDec.stpOverride <= cpuIn.tag[ctm_pkg::VID_STPOVR];
                cpuDec.learnReq    <= 1'b0;
            end
            cpuDec.pri <= cpuIn.tag[ctm_pkg::VID_CALCPR] ? cpuIn.contentPri : cpuIn.tag[15:13];
            cpuDec.vlanRules <= cpuIn.tag[ctm_pkg::VID_VLANRU];
        end
    end

    // left to the CPU; long frames are a MAC setting
    assign egOneHot = 3'h1 << egPort;
    assign egToCpu  = |(egOneHot & egCpuMask);

    always_comb begin
        next_tag = 16'h0000;
        next_tag[15:13] = egInfo.pri;
        next_tag[1:0]   = egInfo.srcPort;
        next_tag[ctm_pkg::VID_LOOKUP] = egInfo.igmpMon;
        // only static host entries fill bits 9:4
        if (egInfo.daFound && egInfo.daStatic) begin
            next_tag[ctm_pkg::VID_STPOVR] = egInfo.daAge;
            next_tag[ctm_pkg::VID_CALCPR] = 1'b1;
            next_tag[ctm_pkg::VID_VLANRU] = egInfo.daPriEn;
            next_tag[ctm_pkg::VID_APRI +: 3] = egInfo.daPri;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            egInsert <= 1'b0;
        end else begin
            egInsert <= egValid && egToCpu;
        end
    end

    // tag fields reloaded from egInfo every cycle, packet or not
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            egTag <= 16'h0000;
        end else begin
            egTag <= next_tag;
        end
    end

    // inner tag kept after the inserted one
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            egInnerFollows <= 1'b0;
        end else begin
            egInnerFollows <= egValid && egInfo.hasInner;
        end
    end

    // Registers, one flop group each; unmapped writes fall through
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mirrorCfg <= 32'h0000_0000;
        end else if (regWr && regAddr == ctm_pkg::OFF_MIRROR) begin
            mirrorCfg <= regWrData & 32'h0000_0777;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inKind <= 6'h00;
        end else if (regWr && regAddr == ctm_pkg::OFF_INKIND) begin
            inKind <= regWrData[5:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            egKind <= 6'h00;
        end else if (regWr && regAddr == ctm_pkg::OFF_EGKIND) begin
            egKind <= regWrData[5:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ingSetup <= 3'h0;
        end else if (regWr && regAddr == ctm_pkg::OFF_INGSET) begin
            ingSetup <= regWrData[2:0];
        end
    end

    // Counters saturate rather than wrap; write clears, but a count in the same cycle wins
    genvar p;
    generate
        for (p = 0; p < ctm_pkg::NPORT; p++) begin : g_cnt
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    lrnCnt[p] <= '0;
                end else if (learnDiscard[p] && !(&lrnCnt[p])) begin
                    lrnCnt[p] <= lrnCnt[p] + 1'b1;
                end else if (regWr && regAddr == ctm_pkg::OFF_LRN0
                             + 8'(p) * ctm_pkg::OFF_STEP) begin
                    lrnCnt[p] <= '0;
                end
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    fltCnt[p] <= '0;
                end else if (ingressFiltered[p] && !rateDrop[p] && !(&fltCnt[p])) begin
                    fltCnt[p] <= fltCnt[p] + 1'b1;
                end else if (regWr && regAddr == ctm_pkg::OFF_FLT0
                             + 8'(p) * ctm_pkg::OFF_STEP) begin
                    fltCnt[p] <= '0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            if (regAddr == ctm_pkg::OFF_MIRROR) begin
                regRdData <= mirrorCfg;
            end else if (regAddr == ctm_pkg::OFF_INKIND) begin
                regRdData <= {26'h0, inKind};
            end else if (regAddr == ctm_pkg::OFF_EGKIND) begin
                regRdData <= {26'h0, egKind};
            end else if (regAddr == ctm_pkg::OFF_INGSET) begin
                regRdData <= {29'h0, ingSetup};
            end else if (regAddr == ctm_pkg::OFF_LRN0) begin
                regRdData <= lrnCnt[0];
            end else if (regAddr == ctm_pkg::OFF_LRN0 + ctm_pkg::OFF_STEP) begin
                regRdData <= lrnCnt[1];
            end else if (regAddr == ctm_pkg::OFF_LRN0 + 2 * ctm_pkg::OFF_STEP) begin
                regRdData <= lrnCnt[2];
            end else if (regAddr == ctm_pkg::OFF_FLT0) begin
                regRdData <= fltCnt[0];
            end else if (regAddr == ctm_pkg::OFF_FLT0 + ctm_pkg::OFF_STEP) begin
                regRdData <= fltCnt[1];
            end else if (regAddr == ctm_pkg::OFF_FLT0 + 2 * ctm_pkg::OFF_STEP) begin
                regRdData <= fltCnt[2];
            end else begin
                regRdData <= 32'h0000_0000;
            end
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end
endmodule : ctm_tag_mirror
`default_nettype wire

// [verification/ctm_tag_mirror_props.sv]
// Port checker for the tag, mirror and counter block.
// Assumes it is bound to ctm_tag_mirror and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ctm_tag_mirror_props (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire ctm_pkg::ctm_fwd_t     fwdIn,
    input wire ctm_pkg::ctm_fwd_t     fwdOut,
    input wire ctm_pkg::ctm_cpu_in_t  cpuIn,
    input wire ctm_pkg::ctm_cpu_dec_t cpuDec,
    input wire logic                  egValid,
    input wire ctm_pkg::ctm_cpu_in_t  egInfo,
    input wire logic                  egInsert,
    input wire logic [15:0]           egTag,
    input wire logic                  egInnerFollows
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence cpuDirect;
        cpuIn.valid && !cpuIn.tag[3];
    endsequence
    sequence cpuLookup;
        cpuIn.valid && cpuIn.tag[3];
    endsequence
    no_echo_a: assert property (fwdIn.valid && fwdIn.srcPort != 2'h3 |=>
        !fwdOut.fwdMask[$past(fwdIn.srcPort)]) else $error("source port in mask");
    idle_fwd_a: assert property (!fwdIn.valid |=> !fwdOut.valid && fwdOut.fwdMask == 3'h0)
        else $error("forward without packet");
    direct_dest_a: assert property (cpuDirect ##0 cpuIn.tag[1:0] != 2'h3 |=> !cpuDec.valid
        || cpuDec.destMask == ((3'h1 << $past(cpuIn.tag[1:0]))
        & ~(3'h1 << $past(cpuIn.srcPort)))) else $error("direct dest wrong");
    stp_force_a: assert property (cpuDirect |=> !cpuDec.valid
        || cpuDec.stpOverride == $past(cpuIn.tag[4])) else $error("override wrong");
    lookup_path_a: assert property (cpuLookup |=> !cpuDec.valid
        || cpuDec.destMask == ($past(cpuIn.lookupMask) & ~(3'h1 << $past(cpuIn.srcPort)))
        && cpuDec.stpOverride == $past(cpuIn.lookupOvr))
        else $error("lookup result wrong");
    pri_pick_a: assert property (cpuIn.valid |=> !cpuDec.valid || cpuDec.pri ==
        ($past(cpuIn.tag[5]) ? $past(cpuIn.contentPri) : $past(cpuIn.tag[15:13])))
        else $error("priority wrong");
    vlan_rule_a: assert property (cpuIn.valid |=> !cpuDec.valid
        || cpuDec.vlanRules == $past(cpuIn.tag[6])) else $error("vlan rule flag wrong");
    tag_strip_a: assert property (cpuIn.valid |=> !cpuDec.valid || cpuDec.skipTag)
        else $error("tag not stripped");
    no_insert_a: assert property (!egValid |=> !egInsert) else $error("stray insert");
    src_field_a: assert property (egValid |=> !egInsert || egTag[1:0] == $past(egInfo.srcPort)
        && egTag[15:13] == $past(egInfo.pri)) else $error("source field wrong");
    learned_zero_a: assert property (egValid && !(egInfo.daFound && egInfo.daStatic) |=>
        !egInsert || egTag[9:4] == 6'h00) else $error("entry bits not zero");
    inner_after_a: assert property (egValid |=> egInnerFollows == $past(egInfo.hasInner))
        else $error("inner tag flag wrong");
endmodule : ctm_tag_mirror_props
bind ctm_tag_mirror ctm_tag_mirror_props ctm_tag_mirror_props_inst (.ref_clk, .rst, .fwdIn,
    .fwdOut, .cpuIn, .cpuDec, .egValid, .egInfo, .egInsert, .egTag, .egInnerFollows);
`default_nettype wire

// [verification/ctm_host_model.sv]
// Host CPU model: sends special-tagged frames into the CPU port.
// Assumes send is called by one process at a time.
`timescale 1ns/1ps
`default_nettype none
module ctm_host_model (
    input  wire logic                ref_clk,
    output var ctm_pkg::ctm_cpu_in_t cpuIn
);
    initial cpuIn = '0;
    task automatic send(input logic [1:0] s, input logic [15:0] t, input logic [2:0] lm,
                        input logic [2:0] cp, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        cpuIn <= '{valid:1'b1, srcPort:s, tag:t, lookupMask:lm, lookupOvr:1'b1, contentPri:cp,
                   default:'0};
        @(posedge ref_clk);
        // Released srcPort, tag and lookupMask show the inverse; the other fields drop to zero
        cpuIn <= '{valid:1'b0, srcPort:~s, tag:~t, lookupMask:~lm, default:'0};
    endtask : send
endmodule : ctm_host_model
`default_nettype wire

// [verification/test_ctm_tag_mirror.sv]
// Self-checking bench for the tag, mirror and counter block.
// Assumes a 100 MHz clock and the plain register port.
`timescale 1ns/1ps
`default_nettype none
module test_ctm_tag_mirror;
    logic                  ref_clk = 1'b0;
    logic                  rst = 1'b1;
    logic [7:0]            regAddr = 8'h00;
    logic [31:0]           regWrData = 32'h0;
    logic                  regWr = 1'b0;
    logic                  regRd = 1'b0;
    logic [31:0]           regRdData;
    ctm_pkg::ctm_fwd_t     fwdIn = '0;
    ctm_pkg::ctm_fwd_t     fwdOut;
    ctm_pkg::ctm_cpu_in_t  cpuIn;
    ctm_pkg::ctm_cpu_dec_t cpuDec;
    logic [1:0]            egPort = 2'h0;
    logic                  egValid = 1'b0;
    ctm_pkg::ctm_cpu_in_t  egInfo = '0;
    logic                  egInsert;
    logic [15:0]           egTag;
    logic                  egInnerFollows;
    logic [2:0]            cpuPortState = 3'h0;
    logic [2:0]            learnDiscard = 3'h0;
    logic [2:0]            ingressFiltered = 3'h0;
    logic [2:0]            rateDrop = 3'h0;
    int                    badCount = 0;
    int                    totalChecks = 0;
    always #5 ref_clk = ~ref_clk;
    ctm_host_model ctm_host_model_inst (.ref_clk(ref_clk), .cpuIn(cpuIn));
    ctm_tag_mirror ctm_tag_mirror_inst (.ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .fwdIn, .fwdOut, .cpuIn, .cpuDec, .egPort, .egValid, .egInfo, .egInsert,
        .egTag, .egInnerFollows, .cpuPortState, .learnDiscard, .ingressFiltered, .rateDrop);
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %s exp %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : printVerdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {regWr, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge ref_clk);
        {regWr, regWrData} <= {1'b0, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        {regRd, regAddr} <= {1'b1, a};
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 check("regRdData", regRdData, exp);
    endtask : rd
    task automatic fwd(input logic [1:0] s, input logic f, input logic [2:0] m, input logic [2:0] e);
        @(posedge ref_clk);
        fwdIn <= '{1'b1, s, f, m};
        @(posedge ref_clk);
        fwdIn <= '{1'b0, ~s, ~f, ~m};
        #1 check("fwdOut", 32'(fwdOut), 32'({1'b1, s, f, e}));
    endtask : fwd
    task automatic ev(input logic [2:0] l, input logic [2:0] f, input logic [2:0] r);
        @(posedge ref_clk);
        {learnDiscard, ingressFiltered, rateDrop} <= {l, f, r};
        @(posedge ref_clk);
        {learnDiscard, ingressFiltered, rateDrop} <= 9'h000;
    endtask : ev
    function automatic ctm_pkg::ctm_cpu_in_t ei(input logic [1:0] s, input logic [2:0] p,
                                                input logic [4:0] f, input logic [2:0] dp,
                                                input logic h);
        return '{srcPort:s, pri:p, igmpMon:f[4], daFound:f[3], daStatic:f[2], daAge:f[1],
                 daPriEn:f[0], daPri:dp, hasInner:h, default:'0};
    endfunction : ei
    task automatic egr(input logic [1:0] p, input ctm_pkg::ctm_cpu_in_t i, input logic [14:0] e);
        @(posedge ref_clk);
        {egPort, egValid, egInfo} <= {p, 1'b1, i};
        @(posedge ref_clk);
        {egValid, egInfo} <= {1'b0, ~i};
        #1 check("egFlags", 32'({egInnerFollows, egInsert}), 32'(e[14:13]));
        if (e[13]) check("egTag", 32'({egTag[15:13], egTag[9:0]}), 32'(e[12:0]));
    endtask : egr
    initial begin
        repeat (2000) @(posedge ref_clk);
        badCount++;
        printVerdict();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        wr(8'h00, 32'hFFF);
        rd(8'h00, 32'h777);
        wr(8'h00, 32'h441);
        fwd(2'h2, 1'b0, 3'h2, 3'h3);
        fwd(2'h2, 1'b0, 3'h1, 3'h1);
        fwd(2'h1, 1'b0, 3'h4, 3'h4);
        fwd(2'h2, 1'b1, 3'h0, 3'h0);
        wr(8'h00, 32'h446);
        fwd(2'h1, 1'b0, 3'h4, 3'h5);
        fwd(2'h0, 1'b0, 3'h4, 3'h4);
        wr(8'h00, 32'h445);
        fwd(2'h2, 1'b1, 3'h0, 3'h1);
        wr(8'h00, 32'h041);
        fwd(2'h2, 1'b0, 3'h2, 3'h2);
        $display("test mirror done");
        wr(8'h04, 32'h03);
        wr(8'h0C, 32'h01);
        for (int d = 0; d < 4; d++) begin
            ctm_host_model_inst.send(2'h0, 16'(d), 3'h0, 3'h0, d);
            #1 check("cpuDec", 32'(cpuDec), 32'({1'b1, ((d == 3) ? 3'h7 : 3'h1 << d) & 3'h6, 7'h02}));
        end
        ctm_host_model_inst.send(2'h0, 16'hA052, 3'h0, 3'h0, 0);
        #1 check("cpuDec", 32'(cpuDec), 32'h66E);
        @(posedge ref_clk) cpuPortState <= 3'h2;
        ctm_host_model_inst.send(2'h0, 16'hE028, 3'h3, 3'h2, 0);
        #1 check("cpuDec", 32'(cpuDec), 32'h553);
        @(posedge ref_clk) cpuPortState <= 3'h4;
        ctm_host_model_inst.send(2'h0, 16'hE028, 3'h3, 3'h2, 1);
        #1 check("cpuDec", 32'(cpuDec), 32'h552);
        ctm_host_model_inst.send(2'h1, 16'hA052, 3'h0, 3'h0, 0);
        #1 check("decValid", 32'(cpuDec.valid), 32'h0);
        $display("test cpu ingress done");
        wr(8'h08, 32'h03);
        egr(2'h0, ei(2'h2, 3'h6, 5'h1F, 3'h5, 1'b1), 15'h7AFA);
        egr(2'h0, ei(2'h1, 3'h3, 5'h0B, 3'h5, 1'b0), 15'h2C01);
        egr(2'h0, ei(2'h0, 3'h0, 5'h0C, 3'h0, 1'b0), 15'h2020);
        egr(2'h1, ei(2'h2, 3'h6, 5'h1F, 3'h5, 1'b1), 15'h4000);
        $display("test cpu egress done");
        for (int p = 0; p < 3; p++) begin
            repeat (p + 1) ev(3'h1 << p, 3'h1 << p, 3'h0);
            ev(3'h0, 3'h1 << p, 3'h1 << p);
            rd(8'h10 + 8'(4 * p), 32'(p + 1));
            rd(8'h20 + 8'(4 * p), 32'(p + 1));
        end
        wr(8'h14, 32'h5);
        rd(8'h14, 32'h0);
        rd(8'h40, 32'h0);
        $display("test counters done");
        printVerdict();
    end
endmodule : test_ctm_tag_mirror
`default_nettype wire
